// ===== core/psc_defines.svh
// Summary of operation
// [R1] vco runs four or two times system clock
// [R2] divider bit zero divides four, one divides two
// [R3] divider bit change needs no relock
// [R4] multiplier or modulus write starts relock
// [R5] comparator input change forces relock
// [R6] lock state readable in control register
// [R7] device held in reset until first lock; with the strap low the code releases reset at once, with no lock
// [R8] slow: one multiplier, six modulus bits, up to 256
// [R9] slow fsys is 4 fref (y+1) 2^(2w+x)
// [R10] fast: feedback multiplier, output path modulus
// [R11] fast fsys is fref/128 times slow formula
// [R12] control resets to 3f00, about 8.388 mhz
// [R13] software sets divider bit above half max
// [R14] strap low: loop off, external clock direct
// [R15] strap high: loop builds clock from reference
// [R16] lock bit reads clear during relock
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// register byte addresses
`define PSC_ADDR_CTRL     4'h0
`define PSC_ADDR_IRQ_STAT 4'h4
`define PSC_ADDR_IRQ_MASK 4'h8

// control register fields and reset
`define PSC_CTRL_RESET    16'h3f00
`define PSC_W_BIT         15
`define PSC_X_BIT         14
`define PSC_Y_MSB         13
`define PSC_Y_LSB         8
`define PSC_LOCK_BIT      3

// interrupt status bits
`define PSC_IRQ_GAINED    0
`define PSC_IRQ_LOST      1
`define PSC_IRQ_W         2

// timing
`define PSC_CLK_MHZ       100
`define PSC_LOCK_TIME_NS  20000
`define PSC_LOCK_CYCLES   ((`PSC_LOCK_TIME_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_STRAP_WAIT    2'h3

`endif

// ===== core/psc_pkg.sv
`default_nettype none
package psc_pkg;
  // clock control sequence
  typedef enum logic [1:0] {
    PSC_ST_STRAP,
    PSC_ST_RELOCK,
    PSC_ST_LOCKED,
    PSC_ST_EXTERNAL
  } psc_state_e;
endpackage
`default_nettype wire

// ===== core/psc_sync.sv
`default_nettype none
module psc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // one two-flop chain per bit; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;  // first stage, metastable
      logic sync_reg;  // second stage, safe
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== core/psc_clock_synth_ctrl.sv
// Chosen here: the address-and-strobe port and the register offsets.
`default_nettype none
`include "psc_defines.svh"
module psc_clock_synth_ctrl
  import psc_pkg::*;
#(
  parameter bit          FAST_REF    = 1'b0,               // 1: fast reference variant
  parameter logic [15:0] LOCK_CYCLES = 16'(`PSC_LOCK_CYCLES) // relock settle time
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // pins and analog status, asynchronous
  input  wire logic        i_clock_source_strap,
  input  wire logic        i_pll_phase_lock,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // synthesizer controls
  output logic             o_pll_enable,
  output logic             o_ext_clock_select,
  output logic             o_ref_prescale_en,
  output logic      [12:0] o_fb_div,
  output logic      [2:0]  o_post_div,
  // status and reset
  output logic             o_pll_locked_flag,
  output logic             o_core_reset_n,
  output logic             o_irq
);

  // how the sequence runs: STRAP waits for the synchroniser to fill, then
  // picks the loop or the external clock; RELOCK counts the settle time and
  // waits for phase agreement; LOCKED holds until a feedback write or a
  // phase loss; EXTERNAL stays until the next reset.
  // limitation: the strap is read once per reset, so moving the pin later
  // has no effect; this is a mode pin, not a live clock select.
  // trade-off: lock needs both the timer and the comparator, so an early
  // glitch of agreement cannot end a relock on its own, at the price of
  // always waiting the full settle time.
  // the fast variant shares the field layout; only the reference prescaler
  // differs, so the same divider ratios serve both parts.

  // reset images of the control fields; a bare literal cannot be
  // part-selected, so the reset word is held in a named constant first
  localparam logic [15:0] CTRL_RST = `PSC_CTRL_RESET;
  localparam logic        W_RST    = CTRL_RST[`PSC_W_BIT];
  localparam logic        X_RST    = CTRL_RST[`PSC_X_BIT];
  localparam logic [5:0]  Y_RST    = CTRL_RST[`PSC_Y_MSB:`PSC_Y_LSB];
  // divider ratios that the reset fields give, 16 (y+1) 4^w and 4 or 2
  localparam logic [12:0] FB_RST   = 13'((int'(Y_RST) + 1) * 16 * (W_RST ? 4 : 1));
  localparam logic [2:0]  POST_RST = X_RST ? 3'h2 : 3'h4;

  // synchronised pin levels: bit 1 strap, bit 0 analog lock
  logic [1:0] sync_levels;
  logic       strap_sync;     // clock source strap after two flops
  logic       phase_ok_sync;  // analog comparator agrees

  // both pins pass two flops before any logic reads them; the strap is
  // only looked at once the chain has surely filled
  psc_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_clock_source_strap, i_pll_phase_lock}),
    .o_sync    (sync_levels)
  );

  // split the synchronised word back into its two meanings
  assign strap_sync    = sync_levels[1];
  assign phase_ok_sync = sync_levels[0];

  // control state
  psc_state_e  state_reg, state_next;        // sequence position
  logic [1:0]  strap_cnt_reg, strap_cnt_next; // waits for sync chain to fill
  logic [15:0] timer_reg, timer_next;        // relock settle countdown
  logic        pll_en_reg, pll_en_next;      // loop running
  logic        ext_sel_reg, ext_sel_next;    // external clock passed straight
  logic        core_rst_n_reg, core_rst_n_next; // released once, never again
  logic        phase_ok_d_reg, phase_ok_d_next; // previous analog lock level
  logic        gained_evt;                   // relock finished this cycle
  logic        lost_evt;                     // locked loop disturbed

  // register state
  logic        w_reg, w_next;                // feedback multiplier bit
  logic        x_reg, x_next;                // output divider select
  logic [5:0]  y_reg, y_next;                // modulus field
  logic [`PSC_IRQ_W-1:0] stat_reg, stat_next; // sticky events
  logic [`PSC_IRQ_W-1:0] mask_reg, mask_next; // event enables
  logic [15:0] rdata_reg, rdata_next;        // read answer
  logic [12:0] fb_div_reg, fb_div_next;      // vco to compare ratio
  logic [2:0]  post_div_reg, post_div_next;  // vco to system clock ratio
  logic        ctrl_wr;                      // write hits control register
  logic        relock_wr;                    // write alters w or y
  logic        phase_drop;                   // comparator input changed
  logic        locked;                       // lock as software sees it

  // decode of control writes; a write of the same w and y, such as an
  // x-only change, keeps the loop locked
  // lock as software sees it follows the state, not the raw comparator
  always_comb begin
    ctrl_wr   = i_wr && (i_addr == `PSC_ADDR_CTRL);
    // only feedback-path fields disturb the loop; x alone never does
    relock_wr = ctrl_wr &&
                ((i_wdata[`PSC_W_BIT] != w_reg) ||
                 (i_wdata[`PSC_Y_MSB:`PSC_Y_LSB] != y_reg)); // [R4] [R3]
    // losing phase agreement means a comparator input moved
    phase_drop = phase_ok_d_reg && !phase_ok_sync; // [R5]
    locked     = (state_reg == PSC_ST_LOCKED); // [R16]
  end

  // next values of the clock control sequence
  // every value except phase_ok_d_next holds unless a branch below moves it; the events default low
  always_comb begin
    state_next      = state_reg;
    strap_cnt_next  = strap_cnt_reg;
    timer_next      = timer_reg;
    pll_en_next     = pll_en_reg;
    ext_sel_next    = ext_sel_reg;
    core_rst_n_next = core_rst_n_reg;
    phase_ok_d_next = phase_ok_sync;
    gained_evt      = 1'b0;
    lost_evt        = 1'b0;
    unique case (state_reg)
      PSC_ST_STRAP: begin
        // strap is caught only once the synchroniser holds the pin level
        if (strap_cnt_reg == `PSC_STRAP_WAIT) begin
          if (strap_sync) begin
            state_next  = PSC_ST_RELOCK; // [R15]
            pll_en_next = 1'b1;          // [R15]
            timer_next  = LOCK_CYCLES;
          end else begin
            state_next      = PSC_ST_EXTERNAL; // [R14]
            ext_sel_next    = 1'b1;            // [R14]
            core_rst_n_next = 1'b1;            // nothing to wait for
          end
        end else begin
          // one more edge while the chain fills
          strap_cnt_next = strap_cnt_reg + 2'h1;
        end
      end
      PSC_ST_RELOCK: begin
        // any new disturbance starts the settle time over
        if (relock_wr || phase_drop) begin
          timer_next = LOCK_CYCLES; // [R4] [R5] restart settle time
        end else if (timer_reg != 16'h0000) begin
          // count down one edge at a time
          timer_next = timer_reg - 16'h0001;
        end else if (phase_ok_sync) begin
          // settle time over and the comparator agrees
          state_next      = PSC_ST_LOCKED;
          gained_evt      = 1'b1;
          core_rst_n_next = 1'b1; // [R7]
        end
      end
      PSC_ST_LOCKED: begin
        // a feedback write or a phase loss ends lock at once
        if (relock_wr || phase_drop) begin
          state_next = PSC_ST_RELOCK; // [R4] [R5]
          timer_next = LOCK_CYCLES;
          lost_evt   = 1'b1;
        end
      end
      PSC_ST_EXTERNAL: begin
        // loop stays off until the next reset
        pll_en_next = 1'b0; // [R14]
      end
    endcase
  end

  // registers of the clock control sequence
  // the core reset flop never returns low once released; only reset does that
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg      <= PSC_ST_STRAP;
      strap_cnt_reg  <= 2'h0;
      timer_reg      <= 16'h0000;
      pll_en_reg     <= 1'b0;
      ext_sel_reg    <= 1'b0;
      core_rst_n_reg <= 1'b0; // [R7]
      phase_ok_d_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      strap_cnt_reg  <= strap_cnt_next;
      timer_reg      <= timer_next;
      pll_en_reg     <= pll_en_next;
      ext_sel_reg    <= ext_sel_next;
      core_rst_n_reg <= core_rst_n_next;
      phase_ok_d_reg <= phase_ok_d_next;
    end
  end

  // next values of the software registers and derived divider settings
  always_comb begin
    logic [6:0]  mod_plus;  // modulus plus one
    logic [12:0] fb_calc;   // feedback ratio before registering
    mod_plus   = 7'h00;
    fb_calc    = 13'h0000;
    // hold by default; only a matching write moves a register
    w_next     = w_reg;
    x_next     = x_reg;
    y_next     = y_reg;
    rdata_next = 16'h0000;
    // control fields; lock bit and spare bits are not stored
    if (ctrl_wr) begin
      w_next = i_wdata[`PSC_W_BIT];
      x_next = i_wdata[`PSC_X_BIT]; // [R3] takes effect with no relock
      y_next = i_wdata[`PSC_Y_MSB:`PSC_Y_LSB];
    end
    // vco sits at 16 (y+1) 4^w times the compare reference on both variants;
    // the fast part reaches that compare rate through the /128 prescaler
    mod_plus = {1'b0, y_next} + 7'h01;              // [R8] [R10]
    fb_calc  = {6'h00, mod_plus} << (w_next ? 6 : 4); // [R9] [R11]
    fb_div_next = fb_calc;
    // post divider sits outside the loop, so a change never restarts relock
    // even post division keeps a 50% duty cycle
    post_div_next = x_next ? 3'h2 : 3'h4; // [R1] [R2]
    // read answer stands only in the cycle after the strobe
    // lock and spare bits are composed here, never stored
    if (i_rd) begin
      unique case (i_addr)
        `PSC_ADDR_CTRL: begin
          rdata_next[`PSC_W_BIT]              = w_reg;
          rdata_next[`PSC_X_BIT]              = x_reg;
          rdata_next[`PSC_Y_MSB:`PSC_Y_LSB]   = y_reg;
          rdata_next[`PSC_LOCK_BIT]           = locked; // [R6] [R16]
        end
        `PSC_ADDR_IRQ_STAT: begin
          rdata_next[`PSC_IRQ_W-1:0] = stat_reg;
        end
        `PSC_ADDR_IRQ_MASK: begin
          rdata_next[`PSC_IRQ_W-1:0] = mask_reg;
        end
        default: begin
          // unmapped addresses read as zero
          rdata_next = 16'h0000;
        end
      endcase
    end
  end

  // registers of the software-visible state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      w_reg        <= W_RST;    // [R12]
      x_reg        <= X_RST;    // [R2] [R12]
      y_reg        <= Y_RST;    // [R12]
      rdata_reg    <= 16'h0000;
      fb_div_reg   <= FB_RST;   // 16 x 64 for the reset fields
      post_div_reg <= POST_RST;
    end else begin
      w_reg        <= w_next;
      x_reg        <= x_next;
      y_reg        <= y_next;
      rdata_reg    <= rdata_next;
      fb_div_reg   <= fb_div_next;
      post_div_reg <= post_div_next;
    end
  end

  // next values of the interrupt status and mask
  always_comb begin
    logic [`PSC_IRQ_W-1:0] clr; // write-one-to-clear pattern
    logic [`PSC_IRQ_W-1:0] evt; // events raised this cycle
    clr       = '0;
    evt       = '0;
    mask_next = mask_reg;
    // the mask takes the whole event layout in one write
    if (i_wr && (i_addr == `PSC_ADDR_IRQ_MASK)) begin
      mask_next = i_wdata[`PSC_IRQ_W-1:0];
    end
    // ones clear their bits, zeros leave bits alone
    if (i_wr && (i_addr == `PSC_ADDR_IRQ_STAT)) begin
      clr = i_wdata[`PSC_IRQ_W-1:0];
    end
    evt[`PSC_IRQ_GAINED] = gained_evt;
    evt[`PSC_IRQ_LOST]   = lost_evt;
    // a new event wins over a clear in the same cycle, so none is lost
    stat_next = (stat_reg & ~clr) | evt;
  end

  // registers of the interrupt state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_reg <= '0; // no event before reset ends
      mask_reg <= '0; // every event masked until software opens it
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  // outputs; software must keep vco in range by setting x itself
  assign o_rdata            = rdata_reg;
  assign o_pll_enable       = pll_en_reg;
  assign o_ext_clock_select = ext_sel_reg;
  assign o_ref_prescale_en  = FAST_REF; // [R11]
  assign o_fb_div           = fb_div_reg;
  assign o_post_div         = post_div_reg;
  // lock flag comes straight from the state register, so it never glitches
  assign o_pll_locked_flag  = locked;
  assign o_core_reset_n     = core_rst_n_reg;
  // irq is a level, high while any unmasked status bit stands
  assign o_irq              = |(stat_reg & mask_reg);

endmodule
`default_nettype wire

// ===== tb/psc_clock_synth_ctrl_assertions.sv
`default_nettype none
module psc_clock_synth_ctrl_checker #(
  parameter bit          FAST_REF    = 1'b0,
  parameter logic [15:0] LOCK_CYCLES = 16'h07d0
) (
  // watched ports
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_pll_phase_lock,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_pll_enable,
  input wire logic        o_ext_clock_select,
  input wire logic        o_ref_prescale_en,
  input wire logic [12:0] o_fb_div,
  input wire logic [2:0]  o_post_div,
  input wire logic        o_pll_locked_flag,
  input wire logic        o_core_reset_n,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // feedback ratio is 16 (y+1) 4^w
  property p_fb;
    i_wr && i_addr == 4'h0 |=> o_fb_div ==
      ((13'($past(i_wdata[13:8])) + 13'h1) << ($past(i_wdata[15]) ? 6 : 4));
  endproperty
  a_fb: assert property (p_fb) else $error("feedback ratio wrong");
  property p_post;
    i_wr && i_addr == 4'h0 |=> o_post_div == ($past(i_wdata[14]) ? 3'h2 : 3'h4);
  endproperty
  a_post: assert property (p_post) else $error("output divider wrong");
  // divider-only change keeps lock
  property p_xkeep;
    o_pll_locked_flag ##1 ($changed(o_post_div) && $stable(o_fb_div)) |-> o_pll_locked_flag;
  endproperty
  a_xkeep: assert property (p_xkeep) else $error("lock lost on divider change");
  property p_relock;
    $changed(o_fb_div) |=> !o_pll_locked_flag [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("no relock gap");
  property p_drop;
    $fell(i_pll_phase_lock) |-> ##[1:4] !o_pll_locked_flag;
  endproperty
  a_drop: assert property (p_drop) else $error("lock kept after phase loss");
  property p_lockbit;
    i_rd && i_addr == 4'h0 |=> o_rdata[3] == $past(o_pll_locked_flag);
  endproperty
  a_lockbit: assert property (p_lockbit) else $error("lock bit mismatch");
  property p_corerst;
    $rose(o_core_reset_n) |-> o_pll_locked_flag || o_ext_clock_select;
  endproperty
  a_corerst: assert property (p_corerst) else $error("reset left before lock");
  property p_ext;
    o_ext_clock_select |-> !o_pll_enable && !o_pll_locked_flag;
  endproperty
  a_ext: assert property (p_ext) else $error("loop active in external mode");
  property p_pre;
    o_ref_prescale_en == FAST_REF;
  endproperty
  a_pre: assert property (p_pre) else $error("prescale flag wrong");
  // main scenarios
  c_lose: cover property (o_pll_locked_flag ##1 !o_pll_locked_flag);
  c_ext: cover property ($rose(o_ext_clock_select));
  c_irq: cover property ($rose(o_irq));
endmodule
bind psc_clock_synth_ctrl psc_clock_synth_ctrl_checker #(
  .FAST_REF(FAST_REF), .LOCK_CYCLES(LOCK_CYCLES)
) u_chk (.i_sys_clk, .i_reset_n, .i_pll_phase_lock, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_pll_enable, .o_ext_clock_select, .o_ref_prescale_en, .o_fb_div,
  .o_post_div, .o_pll_locked_flag, .o_core_reset_n, .o_irq);
`default_nettype wire

// ===== tb/psc_pll_model.sv
`default_nettype none
module psc_pll_model (
  // clock and controls from the block
  input  wire logic        i_sys_clk,
  input  wire logic        i_en,
  input  wire logic [12:0] i_fb,
  input  wire logic        i_drop,
  // comparator agreement
  output logic             o_phase_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt;  // settle countdown
  logic [12:0] fb_q; // last ratio seen
  // a new ratio or a disturbed input restarts settling, as a real loop would
  always_ff @(posedge i_sys_clk) begin
    if (!i_en || i_drop || i_fb != fb_q) begin
      cnt <= 8'h14;
    end else if (cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
    end
    fb_q <= i_fb;
  end
  assign o_phase_lock = i_en && cnt == 8'h0;
endmodule
`default_nettype wire

// ===== tb/psc_clock_synth_ctrl_tb.sv
`default_nettype none
module psc_clock_synth_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 16; // shortened settle time
  logic clk, rst_n, strap, phase, wr, rd, drop;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic pll_en, ext, pre, locked, core_n, irq;
  logic [12:0] fb;
  logic [2:0] post;
  logic pre_f;
  logic [12:0] fb_f;
  int n_fail, total_checks, n;
  psc_clock_synth_ctrl #(.FAST_REF(1'b0), .LOCK_CYCLES(16'(LC))) psc_clock_synth_ctrl_inst (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_clock_source_strap(strap),
    .i_pll_phase_lock(phase), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_pll_enable(pll_en), .o_ext_clock_select(ext),
    .o_ref_prescale_en(pre), .o_fb_div(fb), .o_post_div(post),
    .o_pll_locked_flag(locked), .o_core_reset_n(core_n), .o_irq(irq));
  // fast-reference variant on the same stimulus; only its prescaler differs
  psc_clock_synth_ctrl #(.FAST_REF(1'b1), .LOCK_CYCLES(16'(LC)))
    psc_clock_synth_ctrl_fast_inst (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_clock_source_strap(strap),
    .i_pll_phase_lock(phase), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .o_pll_enable(), .o_ext_clock_select(),
    .o_ref_prescale_en(pre_f), .o_fb_div(fb_f), .o_post_div(),
    .o_pll_locked_flag(), .o_core_reset_n(), .o_irq());
  psc_pll_model psc_pll_model_inst (
    .i_sys_clk(clk), .i_en(pll_en), .i_fb(fb), .i_drop(drop), .o_phase_lock(phase));
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one-cycle strobes, launched just after an edge
  task automatic wrt(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // bounded wait for lock; n returns the cycles spent
  task automatic wlock(output int c);
    c = 0;
    while (locked !== 1'b1 && c < 500) begin
      settle(1);
      c++;
    end
    if (c >= 500) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rst(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  initial begin
    {rst_n, strap, wr, rd, drop, addr, wdata} = '0;
    n_fail = 0;
    total_checks = 0;
    rst(1'b1);
    settle(2);
    chk(16'(fb), 16'h0400);
    chk(16'(post), 16'h0004);
    chk({14'h0, core_n, locked}, 16'h0);
    chk({pre, pre_f, 14'h0}, 16'h4000);
    rdr(4'h0, 16'h3f00);
    wlock(n);
    chk({15'h0, core_n}, 16'h1);
    chk({14'h0, pll_en, ext}, 16'h0002);
    rdr(4'h0, 16'h3f08);
    settle(1);
    chk(rdata, 16'h0000);
    // gained event: masked, then unmasked, then cleared
    chk({15'h0, irq}, 16'h0);
    wrt(4'h8, 16'h0003);
    settle(1);
    chk({15'h0, irq}, 16'h1);
    wrt(4'h4, 16'h0001);
    settle(1);
    chk({15'h0, irq}, 16'h0);
    wrt(4'h0, 16'h7f00);
    settle(1);
    chk({12'h0, post, locked}, 16'h0005);
    wrt(4'h0, 16'h8100);
    settle(2);
    chk({fb, post}, {13'h0080, 3'h4});
    chk(16'(fb_f), 16'h0080);
    chk({15'h0, locked}, 16'h0);
    wlock(n);
    chk(16'(n >= LC - 2), 16'h1);
    rdr(4'h0, 16'h8108);
    // comparator disturbed while locked
    wrt(4'h4, 16'h0003);
    drop <= 1'b1;
    settle(6);
    chk({14'h0, locked, irq}, 16'h0001);
    rdr(4'h4, 16'h0002);
    @(posedge clk);
    drop <= 1'b0;
    wlock(n);
    rdr(4'h4, 16'h0003);
    // unmapped place: reads zero, write ignored
    wrt(4'hc, 16'hffff);
    rdr(4'hc, 16'h0000);
    rdr(4'h0, 16'h8108);
    // external clock mode after a second reset
    rst(1'b0);
    settle(6);
    chk({12'h0, pll_en, ext, core_n, locked}, 16'h0006);
    rdr(4'h0, 16'h3f00);
    complete_run();
  end
endmodule
`default_nettype wire
